// ---- adc_conversion_control.v ----
// Implementation choice: strobed register access.
`include "adc_conv_regs.vh"
`default_nettype none

module adc_conversion_control #(
    parameter CONV_DIV = `CONV_CLOCK_DIV
) (
    input wire clock_i,
    input wire reset_n_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_en_i,
    input wire rd_en_i,
    output reg [7:0] rdata_o,
    // Power modes
    input wire wait_mode_i,
    input wire stop_mode_i,
    output reg irq_o,
    output reg wake_o,
    // Analog converter side
    input wire compare_i,
    output reg [4:0] mux_select_o,
    output reg converter_power_o,
    output wire sample_o,
    output wire [7:0] dac_code_o
);

//==============================================================================
// Declarations
reg flag_reg;
reg irq_en_reg;
reg cont_reg;
reg [4:0] ch_reg;
reg [7:0] result_reg;
reg unread_reg;
reg [2:0] event_reg;
reg [2:0] event_next;
reg [2:0] mask_reg;
reg stop_prev_reg;
reg resume_reg;
reg flag_next;
reg [7:0] rdata_next;
reg cmp_s1_reg;
reg cmp_s2_reg;
reg cmp_s3_reg;
reg cmp_reg;

wire wr_ctrl;
wire rd_result;
wire wr_event;
wire wr_mask;
wire ch_powered;
wire stop_enter;
wire stop_exit;
wire busy;
wire done;
wire [7:0] eng_result;
wire [2:0] ev_set;
wire start_req;
wire start_go;
wire abort;

//==============================================================================
// Register decode
assign wr_ctrl = wr_en_i && (addr_i == `OFS_STATUS_CONTROL);
assign rd_result = rd_en_i && (addr_i == `OFS_RESULT);
assign wr_event = wr_en_i && (addr_i == `OFS_EVENT_STATUS);
assign wr_mask = wr_en_i && (addr_i == `OFS_EVENT_MASK);

//==============================================================================
// Power and stop tracking
// Converter powered when code is not all ones
assign ch_powered = (ch_reg != `CH_POWER_OFF);
assign stop_enter = stop_mode_i && !stop_prev_reg;
assign stop_exit = !stop_mode_i && stop_prev_reg;

//==============================================================================
// Conversion start and abort
// Control write starts, done restarts in continuous, stop exit resumes
assign start_req = (wr_ctrl && (wdata_i[`CH_MSB:`CH_LSB] != `CH_POWER_OFF))
    || (done && cont_reg && ch_powered && !wr_ctrl)
    || (stop_exit && resume_reg && ch_powered && !wr_ctrl);
// Nothing starts while stopped; wait mode does not block
assign start_go = start_req && !stop_mode_i;
// Stop entry or power-off write drops the running conversion
assign abort = stop_enter
    || (wr_ctrl && (wdata_i[`CH_MSB:`CH_LSB] == `CH_POWER_OFF));

//==============================================================================
// Comparator input synchroniser
// Three stages; a change is taken when stages two and three agree
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        cmp_s1_reg <= 1'b0;
        cmp_s2_reg <= 1'b0;
        cmp_s3_reg <= 1'b0;
        cmp_reg <= 1'b0;
    end else begin
        cmp_s1_reg <= compare_i;
        cmp_s2_reg <= cmp_s1_reg;
        cmp_s3_reg <= cmp_s2_reg;
        if (cmp_s2_reg == cmp_s3_reg) begin
            cmp_reg <= cmp_s3_reg;
        end
    end
end

//==============================================================================
// Successive-approximation sequencer
sar_engine #(
    .DIV(CONV_DIV),
    .SAMPLE(`SAMPLE_CLOCKS),
    .BITS(`RESULT_BITS)
) u_sar (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .start_i(start_go),
    .abort_i(abort),
    .compare_i(cmp_reg),
    .trial_o(dac_code_o),
    .sampling_o(sample_o),
    .busy_o(busy),
    .done_o(done),
    .result_o(eng_result)
);

//==============================================================================
// Completion flag next value
always @* begin
    flag_next = flag_reg;
    if (wr_ctrl) begin
        // Writable only with interrupts enabled, otherwise a write clears it
        flag_next = wdata_i[`IRQ_EN_BIT] ? wdata_i[`FLAG_BIT] : 1'b0;
    end else if (rd_result && !irq_en_reg) begin
        flag_next = 1'b0;
    end
    // Completion sets the flag only with interrupts off; set wins over clear
    if (done && !irq_en_reg) begin
        flag_next = 1'b1;
    end
end

//==============================================================================
// Control and result registers
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        flag_reg <= 1'b0;
        irq_en_reg <= 1'b0;
        cont_reg <= 1'b0;
        ch_reg <= `CH_POWER_OFF;
        result_reg <= `RST_RESULT;
        unread_reg <= 1'b0;
    end else begin
        flag_reg <= flag_next;
        if (wr_ctrl) begin
            irq_en_reg <= wdata_i[`IRQ_EN_BIT];
            cont_reg <= wdata_i[`CONT_BIT];
            ch_reg <= wdata_i[`CH_MSB:`CH_LSB];
        end
        // Every completion overwrites the result, read or not
        if (done) begin
            result_reg <= eng_result;
        end
        if (done) begin
            unread_reg <= 1'b1;
        end else if (rd_result) begin
            unread_reg <= 1'b0;
        end
    end
end

//==============================================================================
// Stop mode tracking
// Remember whether work was interrupted so it resumes after stop
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        stop_prev_reg <= 1'b0;
        resume_reg <= 1'b0;
    end else begin
        stop_prev_reg <= stop_mode_i;
        if (stop_enter) begin
            resume_reg <= busy || cont_reg;
        end else if (stop_mode_i && start_req) begin
            resume_reg <= 1'b1;
        end else if (stop_mode_i && wr_ctrl) begin
            resume_reg <= 1'b0;
        end else if (stop_exit) begin
            resume_reg <= 1'b0;
        end
    end
end

//==============================================================================
// Sticky events
// Request at conversion end while interrupts enabled and flag set
assign ev_set[`EV_REQUEST] = done && irq_en_reg && flag_reg;
assign ev_set[`EV_OVERRUN] = done && unread_reg && !rd_result;
assign ev_set[`EV_STOP_ABORT] = stop_enter && busy;

// Write one to clear; result read or control write also drops request
always @* begin
    event_next = event_reg;
    if (wr_event) begin
        event_next = event_reg & ~wdata_i[2:0];
    end
    if (rd_result || wr_ctrl) begin
        event_next[`EV_REQUEST] = 1'b0;
    end
    event_next = event_next | ev_set;
end

always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        event_reg <= 3'h0;
        mask_reg <= `RST_EVENT_MASK;
    end else begin
        event_reg <= event_next;
        if (wr_mask) begin
            mask_reg <= wdata_i[2:0];
        end
    end
end

//==============================================================================
// Interrupt and wake outputs
// Interrupt stays active during wait so it can wake the processor
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        irq_o <= 1'b0;
        wake_o <= 1'b0;
    end else begin
        irq_o <= |(event_reg & mask_reg);
        wake_o <= wait_mode_i && |(event_reg & mask_reg);
    end
end

//==============================================================================
// Analog side outputs
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        mux_select_o <= `CH_POWER_OFF;
        converter_power_o <= 1'b0;
    end else begin
        mux_select_o <= ch_reg;
        // Converter idle in stop mode or with power-off code
        converter_power_o <= ch_powered && !stop_mode_i;
    end
end

//==============================================================================
// Read data mux
always @* begin
    case (addr_i)
        `OFS_STATUS_CONTROL: begin
            rdata_next = {flag_reg, irq_en_reg, cont_reg, ch_reg};
        end
        `OFS_RESULT: begin
            rdata_next = result_reg;
        end
        `OFS_EVENT_STATUS: begin
            rdata_next = {busy, ch_powered, stop_mode_i, 2'b00, event_reg};
        end
        `OFS_EVENT_MASK: begin
            rdata_next = {5'h00, mask_reg};
        end
        default: begin
            rdata_next = 8'h00;
        end
    endcase
end

// Read data stand only in the cycle after the strobe
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        rdata_o <= 8'h00;
    end else begin
        rdata_o <= rd_en_i ? rdata_next : 8'h00;
    end
end

endmodule // adc_conversion_control

`default_nettype wire

// ---- adc_conv_regs.vh ----
//==============================================================================
`ifndef ADC_CONV_REGS_VH
`define ADC_CONV_REGS_VH

//==============================================================================
// Register offsets (byte addresses)
`define OFS_STATUS_CONTROL 8'h38
`define OFS_RESULT 8'h3C
`define OFS_EVENT_STATUS 8'h40
`define OFS_EVENT_MASK 8'h44

//==============================================================================
// Control register fields
`define FLAG_BIT 7
`define IRQ_EN_BIT 6
`define CONT_BIT 5
`define CH_MSB 4
`define CH_LSB 0

//==============================================================================
// Event bits
`define EV_REQUEST 0
`define EV_OVERRUN 1
`define EV_STOP_ABORT 2

//==============================================================================
// Channel codes
`define CH_LAST_PORT 5'h0E
`define CH_HIGH_REF 5'h1D
`define CH_LOW_REF 5'h1E
`define CH_POWER_OFF 5'h1F

//==============================================================================
// Reset values
`define RST_CONTROL 8'h1F
`define RST_RESULT 8'h00
`define RST_EVENT_MASK 3'h1

//==============================================================================
// Timing
`define BUS_PERIOD_NS 8
`define CONV_CLOCK_PERIOD_NS 1000
`define CONV_CLOCK_DIV (`CONV_CLOCK_PERIOD_NS / `BUS_PERIOD_NS)
`define SAMPLE_CLOCKS 8
`define RESULT_BITS 8

`endif

// ---- sar_engine.v ----
`default_nettype none

module sar_engine #(
    parameter DIV = 125,
    parameter SAMPLE = 8,
    parameter BITS = 8
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire start_i,
    input wire abort_i,
    input wire compare_i,
    output reg [BITS-1:0] trial_o,
    output reg sampling_o,
    output reg busy_o,
    output reg done_o,
    output reg [BITS-1:0] result_o
);

reg [15:0] div_reg;
reg [4:0] step_reg;
wire tick;
wire [4:0] bit_idx;
wire [BITS-1:0] cur_bit;
wire [BITS-1:0] trial_next;

//==============================================================================
// Converter clock and bit trials
assign tick = (div_reg == DIV - 1);
assign bit_idx = BITS[4:0] + SAMPLE[4:0] - step_reg;
assign cur_bit = {{(BITS-1){1'b0}}, 1'b1} << bit_idx;
// Binary-weighted trial: keep bit when input is at or above it
assign trial_next = (compare_i ? trial_o : (trial_o & ~cur_bit)) | (cur_bit >> 1);

// Seventeen ticks per conversion; the first only aligns to the converter clock
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        div_reg <= 16'h0000;
        step_reg <= 5'h00;
        trial_o <= {BITS{1'b0}};
        sampling_o <= 1'b0;
        busy_o <= 1'b0;
        done_o <= 1'b0;
        result_o <= {BITS{1'b0}};
    end else begin
        done_o <= 1'b0;
        div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
        if (start_i || abort_i) begin
            busy_o <= start_i;
            sampling_o <= start_i;
            step_reg <= 5'h00;
            trial_o <= {BITS{1'b0}};
        end else if (busy_o && tick) begin
            step_reg <= step_reg + 5'h01;
            if (step_reg == SAMPLE[4:0]) begin
                sampling_o <= 1'b0;
                trial_o <= {1'b1, {(BITS-1){1'b0}}};
            end else if (step_reg > SAMPLE[4:0]) begin
                trial_o <= trial_next;
                if (bit_idx == 5'h00) begin
                    result_o <= trial_next;
                    done_o <= 1'b1;
                    busy_o <= 1'b0;
                end
            end
        end
    end
end

endmodule // sar_engine

`default_nettype wire

// ---- adc_conversion_control_asserts.sv ----
`include "adc_conv_regs.vh"
`default_nettype none
module adc_conversion_control_asserts #(
    parameter CONV_DIV = 125
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rdata_o,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic [4:0] mux_select_o,
    input wire logic converter_power_o,
    input wire logic sample_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] since_reg;
    wire logic ctrl_wr = wr_en_i && addr_i == `OFS_STATUS_CONTROL;
    wire logic start_wr = ctrl_wr && wdata_i[4:0] != `CH_POWER_OFF && !stop_mode_i;
    wire logic res_rd = rd_en_i && addr_i == `OFS_RESULT;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    //==========================================================================
    // Cycles since the last starting control write
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            since_reg <= 16'hFFFF;
        end else if (start_wr) begin
            since_reg <= 16'h0000;
        end else if (since_reg != 16'hFFFF) begin
            since_reg <= since_reg + 16'h0001;
        end
    end
    //==========================================================================
    // Properties
    property p_mux;
        ctrl_wr |=> ##1 mux_select_o == $past(wdata_i[4:0], 2);
    endproperty
    a_mux: assert property (p_mux) else $error("mux select missed write");
    property p_off;
        mux_select_o == `CH_POWER_OFF && $past(mux_select_o) == `CH_POWER_OFF |-> !converter_power_o;
    endproperty
    a_off: assert property (p_off) else $error("powered with off code");
    property p_stop;
        stop_mode_i && $past(stop_mode_i) |-> !converter_power_o;
    endproperty
    a_stop: assert property (p_stop) else $error("powered in stop");
    property p_start;
        start_wr |=> sample_o;
    endproperty
    a_start: assert property (p_start) else $error("no sample after start");
    property p_idle;
        !$past(rd_en_i) |-> rdata_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_drop;
        res_rd || ctrl_wr |=> ##1 !irq_o;
    endproperty
    a_drop: assert property (p_drop) else $error("request not dropped");
    property p_wake;
        wake_o |-> $past(wait_mode_i);
    endproperty
    a_wake: assert property (p_wake) else $error("wake outside wait");
    property p_time;
        $rose(irq_o) && since_reg < 32 * CONV_DIV |->
            since_reg >= 16 * CONV_DIV && since_reg <= 17 * CONV_DIV + 3;
    endproperty
    a_time: assert property (p_time) else $error("conversion length off");
    c_irq: cover property ($rose(irq_o));
    c_wake: cover property (wake_o);
    c_sample: cover property (sample_o ##1 !sample_o);
endmodule // adc_conversion_control_asserts
bind adc_conversion_control adc_conversion_control_asserts #(.CONV_DIV(CONV_DIV)) u_asserts (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o), .wait_mode_i(wait_mode_i),
    .stop_mode_i(stop_mode_i), .irq_o(irq_o), .wake_o(wake_o), .mux_select_o(mux_select_o),
    .converter_power_o(converter_power_o), .sample_o(sample_o));
`default_nettype wire

// ---- analog_side_model.sv ----
`default_nettype none
module analog_side_model (
    input wire logic clock_i,
    input wire logic [4:0] mux_select_i,
    input wire logic power_i,
    input wire logic [7:0] dac_code_i,
    input wire logic [7:0] bias_i,
    output logic compare_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] level;
    logic flip_reg = 1'b0;
    // Node level as a code for the selected input
    always_comb begin
        case (mux_select_i)
            5'h1D: level = 8'hFF;
            5'h1E: level = 8'h00;
            default: level = {mux_select_i[3:0], 4'h5} + bias_i;
        endcase
    end
    // Junk that changes every cycle while unpowered
    always @(posedge clock_i) begin
        flip_reg <= !flip_reg;
    end
    assign compare_o = power_i ? (level >= dac_code_i) : flip_reg;
endmodule // analog_side_model
`default_nettype wire

// ---- test_adc_conversion_control.sv ----
`include "adc_conv_regs.vh"
`default_nettype none
module test_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 5;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic wait_mode_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic [7:0] bias = 8'h00;
    logic [7:0] got;
    logic [4:0] chan [5] = '{5'h00, 5'h07, 5'h0E, 5'h1D, 5'h1E};
    wire logic [7:0] rdata_o;
    wire logic [7:0] dac_code_o;
    wire logic [4:0] mux_select_o;
    wire logic irq_o, wake_o, converter_power_o, sample_o, compare_i;
    int n_mismatch = 0;
    int checks = 0;
    int cyc;
    always #4 clock_i = !clock_i;
    adc_conversion_control #(.CONV_DIV(DIV)) u_dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o), .wait_mode_i(wait_mode_i),
        .stop_mode_i(stop_mode_i), .irq_o(irq_o), .wake_o(wake_o), .compare_i(compare_i),
        .mux_select_o(mux_select_o), .converter_power_o(converter_power_o),
        .sample_o(sample_o), .dac_code_o(dac_code_o));
    analog_side_model u_model (.clock_i(clock_i), .mux_select_i(mux_select_o),
        .power_i(converter_power_o), .dac_code_i(dac_code_o), .bias_i(bias),
        .compare_o(compare_i));
    //==========================================================================
    // Bus cycles, comparisons and bounded waits
    function automatic logic [7:0] code(input logic [4:0] c);
        return c == 5'h1D ? 8'hFF : c == 5'h1E ? 8'h00 : {c[3:0], 4'h5} + bias;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clock_i);
        wr_en_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [7:0] a);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clock_i);
        rd_en_i <= 1'b0;
        @(posedge clock_i);
        got = rdata_o;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_flag;
        cyc = 1;
        got = 8'h00;
        while (got[7] !== 1'b1 && cyc < 160) begin
            rd(`OFS_STATUS_CONTROL);
            cyc += 2;
        end
        if (got[7] !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic wait_irq;
        for (cyc = 0; cyc < 200 && irq_o !== 1'b1; cyc++) @(posedge clock_i);
        if (irq_o !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    //==========================================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        rd(`OFS_STATUS_CONTROL); chk("control", `RST_CONTROL, got);
        rd(`OFS_RESULT); chk("result", `RST_RESULT, got);
        rd(`OFS_EVENT_MASK); chk("mask", {5'h00, `RST_EVENT_MASK}, got);
        rd(8'h50); chk("unmapped", 8'h00, got);
        chk("power", 8'h00, {7'h00, converter_power_o});
        // Settling conversion after leaving the power-off code
        wr(`OFS_STATUS_CONTROL, 8'h00);
        wait_flag();
        foreach (chan[i]) begin
            wr(`OFS_STATUS_CONTROL, {3'b000, chan[i]});
            wait_flag();
            chk("latency", 8'h01, 8'(cyc >= 16 * DIV && cyc <= 17 * DIV + 4));
            rd(`OFS_RESULT); chk("result", code(chan[i]), got);
            rd(`OFS_STATUS_CONTROL); chk("flag", {3'b000, chan[i]}, got);
        end
        repeat (40 * DIV) @(posedge clock_i);
        rd(`OFS_STATUS_CONTROL); chk("single", 8'h1E, got);
        wr(`OFS_STATUS_CONTROL, 8'h03);
        repeat (30) @(posedge clock_i);
        wr(`OFS_STATUS_CONTROL, 8'h05);
        wait_flag();
        chk("restart", 8'h01, 8'(cyc >= 16 * DIV));
        rd(`OFS_RESULT); chk("result", code(5'h05), got);
        wr(`OFS_STATUS_CONTROL, 8'h22);
        wait_flag();
        repeat (34 * DIV) @(posedge clock_i);
        rd(`OFS_STATUS_CONTROL); chk("flag", 8'hA2, got);
        bias <= 8'h10;
        repeat (36 * DIV) @(posedge clock_i);
        rd(`OFS_RESULT); chk("overwrite", code(5'h02), got);
        wr(`OFS_STATUS_CONTROL, 8'h02);
        wait_flag();
        rd(`OFS_RESULT);
        repeat (40 * DIV) @(posedge clock_i);
        rd(`OFS_STATUS_CONTROL); chk("stopped", 8'h02, got);
        wait_mode_i <= 1'b1;
        wr(`OFS_STATUS_CONTROL, 8'hC1);
        rd(`OFS_STATUS_CONTROL); chk("flag rw", 8'hC1, got);
        wait_irq();
        @(posedge clock_i);
        chk("wake", 8'h01, {7'h00, wake_o});
        rd(`OFS_EVENT_STATUS); chk("event", 8'h01, {7'h00, got[0]});
        wr(`OFS_EVENT_MASK, 8'h00);
        @(posedge clock_i);
        chk("masked", 8'h00, {7'h00, irq_o});
        wr(`OFS_EVENT_STATUS, 8'h07);
        wr(`OFS_EVENT_MASK, 8'h01);
        chk("cleared", 8'h00, {7'h00, irq_o});
        wait_mode_i <= 1'b0;
        wr(`OFS_STATUS_CONTROL, 8'hC1);
        wait_irq();
        rd(`OFS_RESULT);
        @(posedge clock_i);
        chk("irq", 8'h00, {7'h00, irq_o});
        rd(`OFS_STATUS_CONTROL); chk("flag rw", 8'hC1, got);
        wr(`OFS_STATUS_CONTROL, 8'h04);
        repeat (20) @(posedge clock_i);
        stop_mode_i <= 1'b1;
        repeat (100) @(posedge clock_i);
        chk("power", 8'h00, {7'h00, converter_power_o});
        rd(`OFS_STATUS_CONTROL); chk("aborted", 8'h04, got);
        rd(`OFS_EVENT_STATUS); chk("stop event", 8'h66, got);
        stop_mode_i <= 1'b0;
        wait_flag();
        // Resumed conversion only settles; trust the next one
        wr(`OFS_STATUS_CONTROL, 8'h04);
        wait_flag();
        rd(`OFS_RESULT); chk("result", code(5'h04), got);
        tally_and_finish();
    end
endmodule // test_adc_conversion_control
`default_nettype wire
